// ==== verilog/ann_autoneg.sv ====
// negotiation, parallel detection, strap decode and crossover control
`timescale 1ns/1ps
`include "ann_consts.svh"

module ann_autoneg #(
  parameter int unsigned BREAK_LINK_CYC = `ANN_BREAK_LINK_CYC,
  parameter int unsigned LINK_FAIL_INHIBIT_CYC = `ANN_LINK_FAIL_INHIBIT_CYC,
  parameter int unsigned MDIX_SLOT_CYC = `ANN_MDIX_SLOT_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic strap_negotiation_enable,
  input wire logic strap_mode_high,
  input wire logic strap_mode_low,
  input wire logic strap_auto_mdix,
  input wire logic link_10_good,
  input wire logic link_100_good,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic tx_flp_en,
  output logic [15:0] tx_word,
  output logic tx_halt,
  output logic link_up,
  output logic speed_100,
  output logic full_duplex,
  output logic mdix_swap
);
  logic rst_meta_q;
  logic rst_n_q;
  ann_pkg::ann_regs_s r_q;
  ann_pkg::ann_regs_s r_d;
  logic [3:0] common;
  logic an_on;
  logic tech_link;
  logic wr_bc;
  logic [15:0] status_word;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // resolved common abilities: 8=100fd 7=100hd 6=10fd 5=10hd
  assign common = r_q.adv[`ANN_ABIL_HI:`ANN_ABIL_LO] & r_q.lpa[`ANN_ABIL_HI:`ANN_ABIL_LO];
  assign an_on = r_q.ctl[`ANN_BC_STRAP_NEGOTIATION_ENABLE] & ~r_q.lock;
  assign tech_link = r_q.spd100 ? r_q.l100[1] : r_q.l10[1];
  assign wr_bc = mgmt_wr && (mgmt_addr == `ANN_OFF_BASIC_CONTROL);
  // fixed abilities plus complete, remote fault, link
  assign status_word = `ANN_STATUS_FIXED | {10'h000, r_q.an_done, r_q.lpa[`ANN_CW_RFAULT], 1'b0,
                       r_q.link_ok, 2'h0};

  always_comb begin
    r_d = r_q;
    // pin synchronisers
    r_d.s_en = {r_q.s_en[0], strap_negotiation_enable};
    r_d.s_hi = {r_q.s_hi[0], strap_mode_high};
    r_d.s_lo = {r_q.s_lo[0], strap_mode_low};
    r_d.s_mdix = {r_q.s_mdix[0], strap_auto_mdix};
    r_d.l10 = {r_q.l10[0], link_10_good};
    r_d.l100 = {r_q.l100[0], link_100_good};
    r_d.lfsr = {r_q.lfsr[14:0], r_q.lfsr[15] ^ r_q.lfsr[13] ^ r_q.lfsr[12] ^ r_q.lfsr[10]};
    r_d.tmr = r_q.tmr + 27'h1;

    // strap capture once synchronisers have settled
    if (!r_q.strap_done) begin
      r_d.cap_cnt = r_q.cap_cnt + 2'h1;
      if (r_q.cap_cnt == 2'h3) begin
        r_d.strap_done = 1'b1;
        r_d.ctl = 16'h0000;
        r_d.adv = {7'h00, `ANN_ABIL_ALL, `ANN_SELECTOR};
        r_d.phy_control = `ANN_PHY_CONTROL_RST;
        r_d.phy_control[`ANN_PC_AUTO_MDIX] = r_q.s_mdix[1];
        if (r_q.s_en[1]) begin
          r_d.ctl[`ANN_BC_STRAP_NEGOTIATION_ENABLE] = 1'b1;
          unique case ({r_q.s_hi[1], r_q.s_lo[1]})
            2'h0: r_d.adv[`ANN_ABIL_HI:`ANN_ABIL_LO] = 4'h3;
            2'h1: r_d.adv[`ANN_ABIL_HI:`ANN_ABIL_LO] = 4'hc;
            2'h2: r_d.adv[`ANN_ABIL_HI:`ANN_ABIL_LO] = 4'h5;
            2'h3: r_d.adv[`ANN_ABIL_HI:`ANN_ABIL_LO] = 4'hf;
          endcase
        end else begin
          r_d.ctl[`ANN_BC_SPEED] = r_q.s_hi[1];
          r_d.ctl[`ANN_BC_DUPLEX] = r_q.s_lo[1];
          r_d.lock = 1'b1;
        end
      end
    end

    // management writes
    if (mgmt_wr && r_q.strap_done) begin
      unique case (mgmt_addr)
        `ANN_OFF_BASIC_CONTROL: begin
          r_d.ctl[`ANN_BC_SPEED] = mgmt_wdata[`ANN_BC_SPEED];
          r_d.ctl[`ANN_BC_STRAP_NEGOTIATION_ENABLE] = mgmt_wdata[`ANN_BC_STRAP_NEGOTIATION_ENABLE];
          r_d.ctl[`ANN_BC_DUPLEX] = mgmt_wdata[`ANN_BC_DUPLEX];
          if (!mgmt_wdata[`ANN_BC_STRAP_NEGOTIATION_ENABLE]) begin
            r_d.lock = 1'b0;
          end
        end
        `ANN_OFF_ADVERTISED: r_d.adv = {mgmt_wdata[15:5], `ANN_SELECTOR};
        `ANN_OFF_PHY_CONTROL: r_d.phy_control = mgmt_wdata;
        default: ;
      endcase
    end

    // management reads, one cycle later
    if (mgmt_rd) begin
      unique case (mgmt_addr)
        `ANN_OFF_BASIC_CONTROL: r_d.rdata = r_q.ctl;
        `ANN_OFF_BASIC_STATUS: r_d.rdata = status_word;
        `ANN_OFF_ADVERTISED: r_d.rdata = r_q.adv;
        `ANN_OFF_PARTNER: r_d.rdata = r_q.lpa;
        `ANN_OFF_EXPANSION: begin
          r_d.rdata = {11'h000, r_q.pd_fault, r_q.lpa[`ANN_CW_NP], 1'b0, r_q.page_rx,
                       r_q.lp_an_able};
          r_d.pd_fault = 1'b0;
          r_d.page_rx = 1'b0;
        end
        `ANN_OFF_SUMMARY: r_d.rdata = {1'b0, r_q.swap, 9'h000, r_q.an_done, 1'b0, r_q.fdx,
                                       ~r_q.spd100, r_q.link_ok};
        `ANN_OFF_PHY_CONTROL: r_d.rdata = r_q.phy_control;
        default: r_d.rdata = 16'h0000;
      endcase
    end

    // negotiation arbitration
    r_d.tx_flp_en = 1'b0;
    r_d.tx_halt = 1'b0;
    unique case (r_q.st)
      ann_pkg::ST_FORCED: begin
        r_d.spd100 = r_q.ctl[`ANN_BC_SPEED];
        r_d.fdx = r_q.ctl[`ANN_BC_DUPLEX];
        r_d.link_ok = tech_link & r_q.strap_done;
        r_d.an_done = 1'b0;
        if (an_on && r_q.strap_done) begin
          r_d.st = ann_pkg::ST_ABILITY;
          r_d.tmr = 27'h0;
          r_d.link_ok = 1'b0;
        end
      end
      ann_pkg::ST_BREAK: begin
        r_d.tx_halt = 1'b1;
        r_d.link_ok = 1'b0;
        if (r_q.tmr >= 27'(BREAK_LINK_CYC - 1)) begin
          r_d.st = ann_pkg::ST_ABILITY;
          r_d.tmr = 27'h0;
        end
      end
      ann_pkg::ST_ABILITY: begin
        r_d.tx_flp_en = 1'b1;
        r_d.tx_word = r_q.adv;
        if (rx_word_valid) begin
          r_d.lpa = rx_word;
          r_d.page_rx = 1'b1;
          r_d.lp_an_able = 1'b1;
          r_d.st = ann_pkg::ST_ACK;
          r_d.tmr = 27'h0;
        end else if (r_q.l10[1] || r_q.l100[1]) begin
          r_d.st = ann_pkg::ST_PARALLEL;
        end else if (r_q.tmr >= 27'(MDIX_SLOT_CYC - 1)) begin
          r_d.tmr = 27'h0;
          if (r_q.phy_control[`ANN_PC_AUTO_MDIX] && r_q.lfsr[0]) begin
            r_d.swap = ~r_q.swap;
          end
        end
      end
      ann_pkg::ST_ACK: begin
        r_d.tx_flp_en = 1'b1;
        r_d.tx_word = r_q.adv;
        r_d.tx_word[`ANN_CW_ACK] = 1'b1;
        if (rx_word_valid) begin
          r_d.lpa = rx_word;
          r_d.page_rx = 1'b1;
          if (rx_word[`ANN_CW_ACK]) begin
            r_d.st = ann_pkg::ST_LINK_CHECK;
            r_d.tmr = 27'h0;
            r_d.spd100 = common[3] | common[2];
            r_d.fdx = common[3] | (~common[2] & common[1]);
            if (common == 4'h0) begin
              r_d.st = ann_pkg::ST_BREAK;
            end
          end
        end else if (r_q.tmr >= 27'(LINK_FAIL_INHIBIT_CYC - 1)) begin
          r_d.st = ann_pkg::ST_BREAK;
          r_d.tmr = 27'h0;
        end
      end
      ann_pkg::ST_PARALLEL: begin
        if (r_q.l10[1] ^ r_q.l100[1]) begin
          r_d.lpa = r_q.l100[1] ? `ANN_PD_100 : `ANN_PD_10;
          r_d.lp_an_able = 1'b0;
          r_d.spd100 = r_q.l100[1];
          r_d.fdx = 1'b0;
          r_d.st = ann_pkg::ST_LINK_CHECK;
          r_d.tmr = 27'h0;
        end else begin
          r_d.pd_fault = 1'b1;
          r_d.st = ann_pkg::ST_ABILITY;
          r_d.tmr = 27'h0;
        end
      end
      ann_pkg::ST_LINK_CHECK: begin
        if (tech_link) begin
          r_d.an_done = 1'b1;
          r_d.link_ok = 1'b1;
          r_d.st = ann_pkg::ST_GOOD;
        end else if (r_q.tmr >= 27'(LINK_FAIL_INHIBIT_CYC - 1)) begin
          r_d.st = ann_pkg::ST_BREAK;
          r_d.tmr = 27'h0;
        end
      end
      ann_pkg::ST_GOOD: begin
        if (!tech_link) begin
          r_d.st = ann_pkg::ST_BREAK;
          r_d.tmr = 27'h0;
          r_d.an_done = 1'b0;
          r_d.link_ok = 1'b0;
        end
      end
      default: r_d.st = ann_pkg::ST_FORCED;
    endcase

    // restart request and enable changes override the arbitration
    if (wr_bc && mgmt_wdata[`ANN_BC_RESTART] && an_on && mgmt_wdata[`ANN_BC_STRAP_NEGOTIATION_ENABLE]) begin
      r_d.st = ann_pkg::ST_BREAK;
      r_d.tmr = 27'h0;
      r_d.an_done = 1'b0;
      r_d.link_ok = 1'b0;
    end
    if (!an_on && (r_q.st != ann_pkg::ST_FORCED)) begin
      r_d.st = ann_pkg::ST_FORCED;
      r_d.an_done = 1'b0;
    end

    if (r_q.phy_control[`ANN_PC_FORCE_MDIX]) begin
      r_d.swap = 1'b1;
    end else if (!r_q.phy_control[`ANN_PC_AUTO_MDIX]) begin
      r_d.swap = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      r_q <= '0;
      r_q.st <= ann_pkg::ST_FORCED;
      r_q.lfsr <= `ANN_LFSR_SEED;
    end else begin
      r_q <= r_d;
    end
  end

  assign mgmt_rdata = r_q.rdata;
  assign tx_flp_en = r_q.tx_flp_en;
  assign tx_word = r_q.tx_word;
  assign tx_halt = r_q.tx_halt;
  assign link_up = r_q.link_ok;
  assign speed_100 = r_q.spd100;
  assign full_duplex = r_q.fdx;
  assign mdix_swap = r_q.swap;
endmodule : ann_autoneg

// ==== verilog/ann_consts.svh ====
// constants for the negotiation and crossover control block
`ifndef ANN_CONSTS_SVH
`define ANN_CONSTS_SVH
`define ANN_OFF_BASIC_CONTROL 5'h00
`define ANN_OFF_BASIC_STATUS 5'h01
`define ANN_OFF_ADVERTISED 5'h04
`define ANN_OFF_PARTNER 5'h05
`define ANN_OFF_EXPANSION 5'h06
`define ANN_OFF_SUMMARY 5'h10
`define ANN_OFF_PHY_CONTROL 5'h19
`define ANN_BC_SPEED 13
`define ANN_BC_STRAP_NEGOTIATION_ENABLE 12
`define ANN_BC_RESTART 9
`define ANN_BC_DUPLEX 8
`define ANN_PC_AUTO_MDIX 15
`define ANN_PC_FORCE_MDIX 14
`define ANN_CW_ACK 14
`define ANN_CW_RFAULT 13
`define ANN_CW_NP 15
`define ANN_ABIL_HI 8
`define ANN_ABIL_LO 5
`define ANN_SELECTOR 5'h01
`define ANN_PD_100 16'h0081
`define ANN_PD_10 16'h0021
`define ANN_ABIL_ALL 4'hf
`define ANN_STATUS_FIXED 16'h7849
`define ANN_PHY_CONTROL_RST 16'h8000
`define ANN_LFSR_SEED 16'h0001
`define ANN_CLK_KHZ 50000
`define ANN_BREAK_LINK_MS 1500
`define ANN_LINK_FAIL_INHIBIT_MS 750
`define ANN_MDIX_SLOT_MS 60
`define ANN_BREAK_LINK_CYC (`ANN_BREAK_LINK_MS * `ANN_CLK_KHZ)
`define ANN_LINK_FAIL_INHIBIT_CYC (`ANN_LINK_FAIL_INHIBIT_MS * `ANN_CLK_KHZ)
`define ANN_MDIX_SLOT_CYC (`ANN_MDIX_SLOT_MS * `ANN_CLK_KHZ)
`endif

// ==== verilog/ann_pkg.sv ====
// types for the negotiation and crossover control block
package ann_pkg;
  typedef enum logic [6:0] {
    ST_FORCED = 7'h01,
    ST_BREAK = 7'h02,
    ST_ABILITY = 7'h04,
    ST_ACK = 7'h08,
    ST_PARALLEL = 7'h10,
    ST_LINK_CHECK = 7'h20,
    ST_GOOD = 7'h40
  } ann_state_e;

  typedef struct packed {
    ann_state_e st;
    logic [26:0] tmr;
    logic [1:0] cap_cnt;
    logic strap_done;
    logic [1:0] s_en;
    logic [1:0] s_hi;
    logic [1:0] s_lo;
    logic [1:0] s_mdix;
    logic [1:0] l10;
    logic [1:0] l100;
    logic [15:0] ctl;
    logic [15:0] adv;
    logic [15:0] lpa;
    logic [15:0] phy_control;
    logic pd_fault;
    logic page_rx;
    logic lp_an_able;
    logic an_done;
    logic lock;
    logic link_ok;
    logic spd100;
    logic fdx;
    logic swap;
    logic [15:0] lfsr;
    logic tx_flp_en;
    logic [15:0] tx_word;
    logic tx_halt;
    logic [15:0] rdata;
  } ann_regs_s;
endpackage : ann_pkg

// ==== tb/ann_checker_properties.sv ====
// assertions on the ports of the negotiation block
`timescale 1ns/1ps
module ann_checker #(
  parameter int unsigned BREAK_LINK_CYC = 40
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_rdata,
  input wire logic tx_flp_en,
  input wire logic [15:0] tx_word,
  input wire logic tx_halt,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic full_duplex
);
  localparam int HMAX = BREAK_LINK_CYC + 9;
  logic [3:0] lp_q;
  logic [3:0] my_q;
  logic [3:0] cm;
  assign cm = lp_q & my_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lp_q <= 4'h0;
      my_q <= 4'h0;
    end else begin
      if (tx_halt) lp_q <= 4'h0;
      else if (rx_word_valid) lp_q <= rx_word[8:5];
      if (tx_flp_en) my_q <= tx_word[8:5];
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  status_fixed_a: assert property (mgmt_rd && mgmt_addr == 5'h01 |=> (mgmt_rdata & 16'hf849) == 16'h7849)
    else $error("fixed status bits wrong");
  halt_quiet_a: assert property (tx_halt |-> !tx_flp_en && !link_up)
    else $error("activity during break");
  halt_hold_a: assert property ($rose(tx_halt) |=> tx_halt [*8])
    else $error("break too short");
  halt_end_a: assert property ($rose(tx_halt) |-> ##[1:HMAX] !tx_halt)
    else $error("break never ends");
  flp_resume_a: assert property ($fell(tx_halt) |-> ##[0:4] tx_flp_en)
    else $error("bursts not resumed");
  selector_a: assert property (tx_flp_en |-> tx_word[4:0] == 5'h01)
    else $error("bad selector");
  ack_reply_a: assert property (rx_word_valid && tx_flp_en && !tx_word[14] |-> ##[1:3] tx_word[14])
    else $error("no acknowledge");
  prio_pick_a: assert property ($rose(link_up) && cm != 4'h0 |->
    speed_100 == (cm[3] | cm[2]) && full_duplex == (cm[3] | (!cm[2] & cm[1])))
    else $error("wrong resolved mode");
  relink_a: assert property ($fell(link_up) && lp_q != 4'h0 |-> ##[0:4] (tx_halt || tx_flp_en))
    else $error("no renegotiation");
endmodule : ann_checker
bind ann_autoneg ann_checker #(.BREAK_LINK_CYC(BREAK_LINK_CYC)) u_chk (.clock(clock), .nrst(nrst),
  .rx_word_valid(rx_word_valid), .rx_word(rx_word), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
  .mgmt_rdata(mgmt_rdata), .tx_flp_en(tx_flp_en), .tx_word(tx_word), .tx_halt(tx_halt),
  .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex));

// ==== tb/ann_partner.sv ====
// model of the remote link partner on the cable
`timescale 1ns/1ps
module ann_partner (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic [3:0] pab,
  input wire logic [3:0] lag,
  input wire logic cut,
  input wire logic tx_flp_en,
  input wire logic [15:0] tx_word,
  input wire logic tx_halt,
  output logic rx_word_valid,
  output logic [15:0] rx_word,
  output logic link_10_good,
  output logic link_100_good
);
  logic [1:0] step;
  logic [3:0] wt;
  logic [3:0] cm;
  logic lk;
  logic neg;
  assign lk = !cut && !tx_halt;
  assign neg = mode == 2'd0 && step == 2'd2;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {step, wt, cm, rx_word_valid, link_10_good, link_100_good} <= '0;
      rx_word <= 16'h0;
    end else begin
      rx_word_valid <= 1'b0;
      rx_word <= ~rx_word;
      link_10_good <= lk && (mode[0] || (neg && cm[3:2] == 2'b00));
      link_100_good <= lk && (mode[1] || (neg && cm[3:2] != 2'b00));
      if (mode != 2'd0 || !lk) begin
        step <= 2'd0;
        wt <= 4'h0;
      end else if (wt != lag) begin
        wt <= wt + 4'h1;
      end else if (step == 2'd0 && tx_flp_en) begin
        rx_word_valid <= 1'b1;
        rx_word <= {7'h0, pab, 5'h01};
        cm <= pab & tx_word[8:5];
        step <= 2'd1;
        wt <= 4'h0;
      end else if (step == 2'd1 && tx_word[14]) begin
        rx_word_valid <= 1'b1;
        rx_word <= {2'b01, 5'h0, pab, 5'h01};
        step <= 2'd2;
      end
    end
  end
endmodule : ann_partner

// ==== tb/tb_ann_autoneg.sv ====
// bench for the negotiation and crossover block
`timescale 1ns/1ps
module tb_ann_autoneg;
  localparam logic [15:0] TBL = 16'hf5c3;
  logic clock, nrst, s_en, s_hi, s_lo, s_mdix, l10, l100, rxv, mwr, mrd, flp, halt, lu, spd, fdx, swp, cut, rd_q, lu_q;
  logic [15:0] rxw, wd, rdata, txw;
  logic [4:0] addr;
  logic [1:0] mode;
  logic [3:0] pab, lag, a, c;
  int fail_count, comparisons, cyc;
  logic [31:0] rq[$];
  logic [1:0] lq[$];
  ann_autoneg #(.BREAK_LINK_CYC(40), .LINK_FAIL_INHIBIT_CYC(30), .MDIX_SLOT_CYC(16)) u_dut (.clock(clock),
    .nrst(nrst), .strap_negotiation_enable(s_en), .strap_mode_high(s_hi), .strap_mode_low(s_lo),
    .strap_auto_mdix(s_mdix), .link_10_good(l10), .link_100_good(l100), .rx_word_valid(rxv), .rx_word(rxw),
    .mgmt_addr(addr), .mgmt_wr(mwr), .mgmt_rd(mrd), .mgmt_wdata(wd), .mgmt_rdata(rdata), .tx_flp_en(flp),
    .tx_word(txw), .tx_halt(halt), .link_up(lu), .speed_100(spd), .full_duplex(fdx), .mdix_swap(swp));
  ann_partner u_lp (.clock(clock), .nrst(nrst), .mode(mode), .pab(pab), .lag(lag), .cut(cut), .tx_flp_en(flp),
    .tx_word(txw), .tx_halt(halt), .rx_word_valid(rxv), .rx_word(rxw), .link_10_good(l10), .link_100_good(l100));
  function automatic logic [1:0] pri(input logic [3:0] x);
    return {x[3] | x[2], x[3] | (!x[2] & x[1])};
  endfunction : pri
  task automatic miss(input string m);
    fail_count++;
    $display("mismatch %0t %s", $time, m);
  endtask : miss
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic cmp_rd(input logic [31:0] n);
    comparisons++;
    if ((rdata & n[31:16]) !== n[15:0]) miss("read data");
  endtask : cmp_rd
  task automatic cmp_flag(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) miss("flags");
  endtask : cmp_flag
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic rst;
    nrst <= 1'b0;
    tick(5);
    nrst <= 1'b1;
    tick(1);
  endtask : rst
  task automatic wr_reg(input logic [4:0] ad, input logic [15:0] d);
    addr <= ad;
    wd <= d;
    mwr <= 1'b1;
    tick(1);
    mwr <= 1'b0;
    tick(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] ad, input logic [15:0] m, input logic [15:0] e);
    rq.push_back({m, e});
    addr <= ad;
    mrd <= 1'b1;
    tick(1);
    mrd <= 1'b0;
    tick(2);
  endtask : rd_reg
  task automatic wait_up(input logic [1:0] e);
    int n;
    n = 0;
    lq.push_back(e);
    while (lu !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    if (lu !== 1'b1) miss("no link");
    if (lu !== 1'b1) lq.delete();
    tick(2);
  endtask : wait_up
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rd_q === 1'b1 && rq.size() > 0) cmp_rd(rq.pop_front());
    if (lu === 1'b1 && lu_q !== 1'b1 && lq.size() > 0) cmp_flag({spd, fdx}, lq.pop_front());
    rd_q <= mrd;
    lu_q <= lu;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miss("timeout");
      end_of_test;
    end
  end
  initial begin
    {nrst, s_en, s_hi, s_lo, mwr, mrd, cut} = '0;
    s_mdix = 1'b1;
    {addr, wd, mode, pab, lag} = '0;
    void'($urandom(6377));
    for (int i = 0; i < 4; i++) begin
      s_en <= 1'b0;
      {s_hi, s_lo} <= i[1:0];
      mode <= i[1] ? 2'd2 : 2'd1;
      rst;
      wait_up(i[1:0]);
    end
    rd_reg(5'h19, 16'hc000, 16'h8000);
    wr_reg(5'h19, 16'h4000);
    rd_reg(5'h10, 16'h4000, 16'h4000);
    cmp_flag({swp, 1'b0}, 2'b10);
    rd_reg(5'h02, 16'hffff, 16'h0000);
    mode <= 2'd0;
    pab <= 4'hf;
    wr_reg(5'h00, 16'h3100);
    tick(60);
    cmp_flag({flp, halt}, 2'b00);
    wr_reg(5'h00, 16'h2100);
    wr_reg(5'h00, 16'h3100);
    wait_up(2'b11);
    wr_reg(5'h00, 16'h1200);
    tick(5);
    wait_up(2'b11);
    cut <= 1'b1;
    tick(60);
    wr_reg(5'h00, 16'h2000);
    mode <= 2'd2;
    cut <= 1'b0;
    wait_up(2'b10);
    for (int i = 0; i < 4; i++) begin
      a = TBL[i*4 +: 4];
      c = 4'($urandom);
      if ((c & a) == 4'h0) c = a;
      s_en <= 1'b1;
      {s_hi, s_lo} <= i[1:0];
      mode <= 2'd0;
      pab <= c;
      lag <= 4'($urandom);
      rst;
      wait_up(pri(a & c));
      rd_reg(5'h04, 16'h01ff, {7'h0, a, 5'h01});
      rd_reg(5'h05, 16'h01ff, {7'h0, c, 5'h01});
      rd_reg(5'h06, 16'h0001, 16'h0001);
      rd_reg(5'h01, 16'h0024, 16'h0024);
    end
    a = 4'($urandom);
    if ((a & c) == 4'h0) a = c;
    wr_reg(5'h04, {7'h0, a, 5'h01});
    wr_reg(5'h00, 16'h1200);
    tick(5);
    wait_up(pri(a & c));
    for (int m = 1; m < 4; m++) begin
      mode <= m[1:0];
      rst;
      if (m < 3) begin
        wait_up({m[1], 1'b0});
        rd_reg(5'h05, 16'hffff, m[1] ? 16'h0081 : 16'h0021);
        rd_reg(5'h06, 16'h0001, 16'h0000);
        rd_reg(5'h01, 16'h0020, 16'h0020);
      end else begin
        tick(300);
        cmp_flag({lu, halt}, 2'b00);
        rd_reg(5'h06, 16'h0010, 16'h0010);
      end
    end
    end_of_test;
  end
endmodule : tb_ann_autoneg
